// [bank_chk_assertions.sv]
// Assertions on the status bank ports.
// Assumes binding to the bank top module.
`timescale 1ns/10ps
module bank_chk (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Bank ports
   input wire status_bank_pkg::reg_req_type req,
   input wire logic [15:0] rdata,
   input wire status_bank_pkg::live_status_type live,
   input wire status_bank_pkg::chan_status_type rx_chan_status_bit
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!reset_n);
   wire logic [31:0] s = {9'h0, live[11:5], 13'h0, live[4], 1'b0, live[3]};
   wire logic [15:0] t = {7'h0, live[2], 6'h0, live[1:0]};
   wire logic [79:0] c = rx_chan_status_bit;
   property p(logic [7:0] a, logic [15:0] v);
      req.rd && req.addr == a |=> rdata == $past(v, 2);
   endproperty
   interp_read_a: assert property (p(8'h18, s[31:16])) else $error("interp");
   decim_read_a: assert property (p(8'h28, s[15:0])) else $error("decim");
   din_read_a: assert property (p(8'h59, t)) else $error("din");
   left_low_a: assert property (p(8'h5A, c[55:40])) else $error("cs");
   right_mid_a: assert property (p(8'h5E, c[31:16])) else $error("cs");
   left_high_a: assert property (p(8'h5C, {8'h0, c[79:72]})) else $error("cs");
   right_high_a: assert property (p(8'h5F, {8'h0, c[39:32]})) else $error("cs");
   idle_zero_a: assert property (!req.rd |=> rdata == 16'h0) else $error("idle");
   cover property (req.rd && req.addr == 8'h59);
   cover property (req.rd && req.addr == 8'h60);
   cover property (req.wr && req.addr == 8'h61);
endmodule
bind codec_readback_status_bank bank_chk chk (.core_clk(core_clk), .reset_n(reset_n),
   .req(req), .rdata(rdata), .live(live), .rx_chan_status_bit(rx_chan_status_bit));

// [codec_readback_status_bank.sv]
// Status register bank of a stereo audio codec, read-only except the interrupt registers.
// Assumes all status inputs are synchronous levels from the codec core.
//
// Behaviour
// - Bits 6..3 report silence per input
// - Bit 2 reports whole interpolator muted
// - Bits 1,0 report channel mutes
// - Interpolator bits 15..7 are reserved
// - Decimator bit 2 reports decimator mute
// - Decimator bit 0 reports overflow
// - Bit 8 reports transmitter output disabled
// - Bit 1 reports biphase coding error
// - Bit 0 reports receiver lock
// - Status bits 39..32 in high registers
// - Status bits 31..16 in mid registers
// - Status bits 15..0 in low registers
// - Received bits keep transmitter bit meaning
// - Bit 1 audio/non-audio, bit 0 consumer
// - Bits 23..16 channel and source numbers
// - Bits 35..32 encode word length
`timescale 1ns/10ps
module codec_readback_status_bank (
   // Clock and reset
   input wire logic core_clk,
   input wire logic reset_n,
   // Register port
   input wire status_bank_pkg::reg_req_type req,
   output logic [15:0] rdata,
   // Live status from the codec core
   input wire status_bank_pkg::live_status_type live,
   input wire status_bank_pkg::chan_status_type rx_chan_status_bit,
   // Interrupt
   output logic irq
);

   typedef struct packed {
      status_bank_pkg::live_status_type live;
      status_bank_pkg::chan_status_type cs;
      logic [status_bank_pkg::event_count-1:0] ev_status;
      logic [status_bank_pkg::event_count-1:0] ev_mask;
      logic [15:0] rdata;
      logic irq;
   } state_type;

   state_type state_reg;
   state_type state_next;

   logic [15:0] rd_word;
   logic [status_bank_pkg::event_count-1:0] ev_raw;

   // Register view assembly
   always_comb begin
      rd_word = status_bank_pkg::data_reset;
      unique case (req.addr)
         status_bank_pkg::interp_status_addr: begin
            rd_word[status_bank_pkg::silence_ch2_right_bit] = state_reg.live.silence[3];
            rd_word[status_bank_pkg::silence_ch2_left_bit] = state_reg.live.silence[2];
            rd_word[status_bank_pkg::silence_ch1_right_bit] = state_reg.live.silence[1];
            rd_word[status_bank_pkg::silence_ch1_left_bit] = state_reg.live.silence[0];
            rd_word[status_bank_pkg::interp_all_muted_bit] =
               state_reg.live.interp_all_muted;
            rd_word[status_bank_pkg::interp_second_muted_bit] =
               state_reg.live.interp_second_muted;
            rd_word[status_bank_pkg::interp_first_muted_bit] =
               state_reg.live.interp_first_muted;
            // Upper bits stay zero
         end
         status_bank_pkg::decim_status_addr: begin
            rd_word[status_bank_pkg::decim_muted_bit] = state_reg.live.decim_muted;
            rd_word[status_bank_pkg::decim_overflow_bit] =
               state_reg.live.decim_overflow;
         end
         status_bank_pkg::din_status_addr: begin
            rd_word[status_bank_pkg::tx_output_disabled_bit] =
               state_reg.live.tx_output_disabled;
            rd_word[status_bank_pkg::biphase_error_bit] =
               state_reg.live.biphase_error;
            rd_word[status_bank_pkg::rx_locked_bit] = state_reg.live.rx_locked;
         end
         // Channel status words pass unchanged
         status_bank_pkg::cs_left_low_addr: rd_word = state_reg.cs.left[15:0];
         status_bank_pkg::cs_left_mid_addr: rd_word = state_reg.cs.left[31:16];
         status_bank_pkg::cs_left_high_addr: rd_word = {8'h00, state_reg.cs.left[39:32]};
         status_bank_pkg::cs_right_low_addr: rd_word = state_reg.cs.right[15:0];
         status_bank_pkg::cs_right_mid_addr: rd_word = state_reg.cs.right[31:16];
         status_bank_pkg::cs_right_high_addr: rd_word = {8'h00, state_reg.cs.right[39:32]};
         status_bank_pkg::irq_status_addr: rd_word = {12'h000, state_reg.ev_status};
         status_bank_pkg::irq_mask_addr: rd_word = {12'h000, state_reg.ev_mask};
         default: rd_word = status_bank_pkg::data_reset;
      endcase
   end

   // Event detection on the captured status
   always_comb begin
      ev_raw = '0;
      ev_raw[status_bank_pkg::ev_lock_change_bit] =
         live.rx_locked ^ state_reg.live.rx_locked;
      ev_raw[status_bank_pkg::ev_biphase_error_bit] =
         live.biphase_error & ~state_reg.live.biphase_error;
      ev_raw[status_bank_pkg::ev_overflow_bit] =
         live.decim_overflow & ~state_reg.live.decim_overflow;
      ev_raw[status_bank_pkg::ev_cs_change_bit] = (rx_chan_status_bit != state_reg.cs);
   end

   // Next-state logic
   always_comb begin
      state_next = state_reg;
      state_next.live = live;
      state_next.cs = rx_chan_status_bit;
      state_next.rdata = req.rd ? rd_word : status_bank_pkg::data_reset;
      // Only interrupt registers accept writes
      if (req.wr && req.addr == status_bank_pkg::irq_mask_addr) begin
         state_next.ev_mask = req.wdata[status_bank_pkg::event_count-1:0];
      end
      if (req.wr && req.addr == status_bank_pkg::irq_status_addr) begin
         state_next.ev_status = state_reg.ev_status & ~req.wdata[status_bank_pkg::event_count-1:0];
      end
      // Set wins over a same-cycle clear
      state_next.ev_status = state_next.ev_status | ev_raw;
      state_next.irq = |(state_next.ev_status & state_next.ev_mask);
   end

   always_ff @(posedge core_clk or negedge reset_n) begin
      if (!reset_n) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign rdata = state_reg.rdata;
   assign irq = state_reg.irq;

endmodule

// [codec_readback_status_bank_test.sv]
// Bench for the status bank over its register port.
// Assumes the core model and the bound checker.
`timescale 1ns/10ps
module codec_readback_status_bank_test;
   logic core_clk = 1'b0, reset_n = 1'b0, irq;
   logic [25:0] req = '0;
   logic [11:0] lv = '0;
   logic [39:0] p = 40'h2B_C3F0_96E1;
   logic [79:0] cs;
   logic [15:0] rdata;
   int err_total = 0, check_count = 0;
   core_model core (.pat(p), .cs(cs));
   codec_readback_status_bank dut (.core_clk(core_clk), .reset_n(reset_n), .req(req),
      .rdata(rdata), .live(lv), .rx_chan_status_bit(cs), .irq(irq));
   initial forever #5 core_clk = ~core_clk;
   task check(input logic [15:0] seen, input logic [15:0] exp);
      check_count++;
      err_total += int'(seen !== exp);
      if (seen !== exp) $display("CHECK FAILED value exp %h seen %h", exp, seen);
   endtask
   task acc(input logic w, input logic [7:0] a, input logic [15:0] d);
      @(posedge core_clk) req <= {a, d, w, !w};
      @(posedge core_clk) req <= '0;
      #1 check(rdata, w ? 16'h0 : d);
   endtask
   task end_of_test;
      if (err_total == 0 && check_count > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      reset_n <= 1'b1;
      for (int i = 0; i < 13; i++) begin
         lv <= (i < 12) ? 12'h1 << i : 12'hFFF;
         acc(1, 8'h18, 16'hFFFF);
         acc(0, 8'h18, {9'h0, lv[11:5]});
         acc(0, 8'h28, {13'h0, lv[4], 1'b0, lv[3]});
         acc(0, 8'h59, {7'h0, lv[2], 6'h0, lv[1:0]});
      end
      p <= ~p;
      acc(0, 8'h30, 16'h0000);
      acc(0, 8'h5A, {p[15:1], 1'b0});
      acc(0, 8'h5B, {p[31:24], 4'h1, p[19:16]});
      acc(0, 8'h5C, {8'h0, p[39:32]});
      acc(0, 8'h5D, ~{p[15:1], 1'b1});
      acc(0, 8'h5E, {~p[31:24], 4'h2, ~p[19:16]});
      acc(0, 8'h5F, {8'h0, ~p[39:32]});
      acc(0, 8'h60, 16'h000F);
      acc(1, 8'h61, 16'h0008);
      @(posedge core_clk) #1 check({15'h0, irq}, 16'h0001);
      acc(1, 8'h61, 16'h0000);
      @(posedge core_clk) #1 check({15'h0, irq}, 16'h0000);
      acc(1, 8'h60, 16'h000F);
      acc(0, 8'h60, 16'h0000);
      end_of_test;
   end
endmodule

// [core_model.sv]
// Receiver model of the codec core feeding the bank.
// Assumes the bench picks the status pattern.
`timescale 1ns/10ps
module core_model (
   // Pattern in, channel status out
   input wire logic [39:0] pat,
   output logic [79:0] cs
);
   assign cs = {pat[39:24], 4'h1, pat[19:1], 1'b0,
      ~pat[39:24], 4'h2, ~pat[19:1], 1'b0};
endmodule

// [status_bank_pkg.sv]
// Constants and carrier types for the codec readback status bank.
// Assumes a single core clock domain and a plain register port.
package status_bank_pkg;

   // Register offsets (one 16-bit register per address on the plain port)
   localparam logic [7:0] interp_status_addr = 8'h18;
   localparam logic [7:0] decim_status_addr = 8'h28;
   localparam logic [7:0] din_status_addr = 8'h59;
   localparam logic [7:0] cs_left_low_addr = 8'h5A;
   localparam logic [7:0] cs_left_mid_addr = 8'h5B;
   localparam logic [7:0] cs_left_high_addr = 8'h5C;
   localparam logic [7:0] cs_right_low_addr = 8'h5D;
   localparam logic [7:0] cs_right_mid_addr = 8'h5E;
   localparam logic [7:0] cs_right_high_addr = 8'h5F;
   localparam logic [7:0] irq_status_addr = 8'h60;
   localparam logic [7:0] irq_mask_addr = 8'h61;

   // Field positions
   localparam int silence_ch2_right_bit = 6;
   localparam int silence_ch2_left_bit = 5;
   localparam int silence_ch1_right_bit = 4;
   localparam int silence_ch1_left_bit = 3;
   localparam int interp_all_muted_bit = 2;
   localparam int interp_second_muted_bit = 1;
   localparam int interp_first_muted_bit = 0;
   localparam int decim_muted_bit = 2;
   localparam int decim_overflow_bit = 0;
   localparam int tx_output_disabled_bit = 8;
   localparam int biphase_error_bit = 1;
   localparam int rx_locked_bit = 0;

   // Event bit positions in the interrupt status and mask registers
   localparam int ev_lock_change_bit = 0;
   localparam int ev_biphase_error_bit = 1;
   localparam int ev_overflow_bit = 2;
   localparam int ev_cs_change_bit = 3;
   localparam int event_count = 4;

   // Reset values and channel status width
   localparam logic [15:0] data_reset = 16'h0000;
   localparam logic [event_count-1:0] mask_reset = 4'h0;
   localparam int cs_bits = 40;

   typedef struct packed {
      logic [7:0] addr;
      logic [15:0] wdata;
      logic wr;
      logic rd;
   } reg_req_type;

   typedef struct packed {
      logic [3:0] silence;
      logic interp_all_muted;
      logic interp_second_muted;
      logic interp_first_muted;
      logic decim_muted;
      logic decim_overflow;
      logic tx_output_disabled;
      logic biphase_error;
      logic rx_locked;
   } live_status_type;

   typedef struct packed {
      logic [cs_bits-1:0] left;
      logic [cs_bits-1:0] right;
   } chan_status_type;

endpackage
